// ### logic/irr_router.sv
// top: config registers, divider select and host interrupt multiplexer
//
// Added by the designer: the strobed register port.
`default_nettype none

module irr_router (
	input  wire logic                sys_clk,       // 50 MHz clock
	input  wire logic                arst_n,        // async reset, low
	input  wire logic [7:0]          reg_addr,      // register address
	input  wire logic [7:0]          reg_wdata,     // write data
	input  wire logic                reg_wr,        // write strobe
	input  wire logic                reg_rd,        // read strobe
	output logic      [7:0]          reg_rdata,     // read data, next cycle
	input  wire logic [2:0]          chip_mode,     // chip mode code
	input  wire logic [1:0]          data_mode,     // data mode code
	input  wire logic                frequency_select, // 0 set one, 1 two
	input  wire logic                address_compare_enable, // addr cmp on
	input  wire logic [6:0]          fill_count,    // bytes in buffer
	input  wire irr_pkg::irr_events_t events,       // internal sources
	output irr_pkg::irr_synth_t      synth_div,     // active divider set
	output logic [6:0]               buffer_size,   // 16..64 bytes
	output logic [6:0]               thresh_bytes,  // threshold count
	output logic                     buffer_full,   // count at size
	output logic                     buffer_not_empty, // count nonzero
	output logic                     host_int_line_a, // interrupt line 0
	output logic                     host_int_line_b  // interrupt line 1
);
	// =====================================================
	// reset release
	logic rst_s1_r;
	logic rst_n_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// =====================================================
	// register file
	logic [7:0] regs_r [0:7];
	logic [7:0] regs_nxt [0:7];
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	// constants only, so the async reset branch loads no net
	localparam logic [7:0] RST_VAL [0:7] = '{
		irr_pkg::RST_F1_R,
		irr_pkg::RST_F1_P,
		irr_pkg::RST_F1_S,
		irr_pkg::RST_F2_R,
		irr_pkg::RST_F2_P,
		irr_pkg::RST_F2_S,
		irr_pkg::RST_BUF_CFG,
		irr_pkg::RST_IRQ_ROUT
	};
	logic [2:0] idx;
	logic       hit;

	logic [7:0] rel;
	assign rel = reg_addr - irr_pkg::OFS_F1_R;
	assign hit = (reg_addr >= irr_pkg::OFS_F1_R)
		&& (reg_addr <= irr_pkg::OFS_IRQ_ROUT);
	assign idx = rel[2:0];

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			regs_nxt[i] = regs_r[i];
		end
		if (reg_wr && hit) begin
			regs_nxt[idx] = reg_wdata;
		end
		// status bits are hardware-owned, never stored
		regs_nxt[7][1:0] = 2'h0;
		rdata_nxt = 8'h00;
		if (reg_rd && hit) begin
			rdata_nxt = regs_r[idx];
			if (idx == 3'h7) begin
				rdata_nxt[irr_pkg::FULL_BIT]   = buffer_full;
				rdata_nxt[irr_pkg::NEMPTY_BIT] = buffer_not_empty;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_reg
			always_ff @(posedge sys_clk or negedge rst_n_r) begin
				if (!rst_n_r) begin
					regs_r[g] <= RST_VAL[g];
				end else begin
					regs_r[g] <= regs_nxt[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;

	// =====================================================
	// synthesizer divider select
	irr_pkg::irr_synth_t set1;
	irr_pkg::irr_synth_t set2;
	assign set1 = {regs_r[0], regs_r[1], regs_r[2]};
	assign set2 = {regs_r[3], regs_r[4], regs_r[5]};
	assign synth_div = frequency_select ? set2 : set1;

	// =====================================================
	// buffer size and threshold
	logic [1:0] size_code;
	logic [5:0] thr_field;
	logic       thr_event;
	assign size_code = regs_r[6][irr_pkg::SIZE_LSB +: 2];
	assign thr_field = regs_r[6][5:0];
	// (code+1)*16 gives 16,32,48,64
	assign buffer_size = 7'({5'h00, size_code} + 7'h01)
		* irr_pkg::SIZE_UNIT;
	assign thresh_bytes = {1'b0, thr_field} + 7'h01;
	assign thr_event = fill_count >= thresh_bytes;
	assign buffer_full = fill_count >= buffer_size;
	assign buffer_not_empty = fill_count != 7'h00;

	// =====================================================
	// interrupt multiplexer
	logic [1:0] rx0_sel;
	logic [1:0] rx1_sel;
	logic       tx0_sel;
	logic       tx1_sel;
	logic       line_a;
	logic       line_b;
	assign rx0_sel = regs_r[7][irr_pkg::RX0_LSB +: 2];
	assign rx1_sel = regs_r[7][irr_pkg::RX1_LSB +: 2];
	assign tx0_sel = regs_r[7][irr_pkg::TX0_BIT];
	assign tx1_sel = regs_r[7][irr_pkg::TX1_BIT];

	always_comb begin
		line_a = 1'b0;
		line_b = 1'b0;
		case (chip_mode)
			irr_pkg::CM_RX: begin
				case (data_mode)
					irr_pkg::DM_CONT: begin
						case (rx0_sel)
							2'h0: line_a = events.pattern;
							2'h1: line_a = events.signal_strength_event;
							default: line_a = events.start_detect;
						endcase
						line_b = events.recovered_bit_clock;
					end
					irr_pkg::DM_BUF: begin
						case (rx0_sel)
							2'h0: line_a = 1'b0;
							2'h1: line_a = events.byte_written;
							2'h2: line_a = buffer_not_empty;
							default: line_a = events.start_detect;
						endcase
						case (rx1_sel)
							2'h0: line_b = 1'b0;
							2'h1: line_b = buffer_full;
							2'h2: line_b = events.signal_strength_event;
							default: line_b = thr_event;
						endcase
					end
					default: begin
						case (rx0_sel)
							2'h0: line_a = events.data_ready;
							2'h1: line_a = events.byte_written;
							2'h2: line_a = buffer_not_empty;
							default: line_a = address_compare_enable
								? events.addr_match
								: events.start_detect;
						endcase
						case (rx1_sel)
							2'h0: line_b = events.crc_good;
							2'h1: line_b = buffer_full;
							2'h2: line_b = events.signal_strength_event;
							default: line_b = thr_event;
						endcase
					end
				endcase
			end
			irr_pkg::CM_TX: begin
				if (data_mode == irr_pkg::DM_CONT) begin
					line_a = 1'b0;
					line_b = events.recovered_bit_clock;
				end else begin
					line_a = tx0_sel ? buffer_not_empty : thr_event;
					line_b = tx1_sel ? events.tx_stop : buffer_full;
				end
			end
			irr_pkg::CM_STANDBY: begin
				// only the selections that stay valid in standby
				if (data_mode != irr_pkg::DM_CONT) begin
					line_a = (rx0_sel == 2'h2) && buffer_not_empty;
					if (rx1_sel == 2'h3) begin
						line_b = thr_event;
					end else if (rx1_sel == 2'h1
						&& data_mode != irr_pkg::DM_BUF) begin
						line_b = buffer_full;
					end
				end
			end
			default: begin
				line_a = 1'b0;
				line_b = 1'b0;
			end
		endcase
	end
	// combinational so the recovered clock passes with no delay
	assign host_int_line_a = line_a;
	assign host_int_line_b = line_b;

	// =====================================================
	// checks
	AST_READ_TIMING: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		reg_rd && reg_addr == irr_pkg::OFS_F1_S ##1 1'b1
		|-> reg_rdata == $past(regs_r[2]))
		else $error("divider readback wrong");
	AST_FREQ_SEL: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		frequency_select |-> synth_div.r == regs_r[3])
		else $error("second divider set not selected");
	AST_SIZE: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		size_code == 2'h3 |-> buffer_size == 7'd64)
		else $error("buffer size wrong");
	AST_THRESH: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		fill_count == thresh_bytes |-> thr_event)
		else $error("threshold event missing");
	AST_TX_CONT_A: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		chip_mode == irr_pkg::CM_TX && data_mode == irr_pkg::DM_CONT
		|-> !host_int_line_a)
		else $error("tx continuous line a not low");
	AST_TX_B: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		chip_mode == irr_pkg::CM_TX && data_mode != irr_pkg::DM_CONT
		&& tx1_sel |-> host_int_line_b == events.tx_stop)
		else $error("tx line b not tx stop");
	AST_RX_CONT_B: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		chip_mode == irr_pkg::CM_RX && data_mode == irr_pkg::DM_CONT
		|-> host_int_line_b == events.recovered_bit_clock)
		else $error("rx continuous line b not bit clock");
	AST_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		reg_rd && reg_addr == irr_pkg::OFS_IRQ_ROUT && fill_count == 7'h00
		|=> reg_rdata[0] == 1'b0)
		else $error("not-empty status set on empty buffer");
	AST_SLEEP: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
		chip_mode == 3'h0 |-> !host_int_line_a && !host_int_line_b)
		else $error("lines active in sleep");

	// =====================================================
	// routing checks by selection code, then flag, divider, standby routing, reset and size checks
	logic rx_cont;
	logic rx_buf;
	logic rx_pkt;
	logic tx_fb;
	assign rx_cont = chip_mode == irr_pkg::CM_RX
		&& data_mode == irr_pkg::DM_CONT;
	assign rx_buf = chip_mode == irr_pkg::CM_RX
		&& data_mode == irr_pkg::DM_BUF;
	assign rx_pkt = chip_mode == irr_pkg::CM_RX && data_mode[1];
	assign tx_fb = chip_mode == irr_pkg::CM_TX
		&& data_mode != irr_pkg::DM_CONT;

	AST_RX_CONT_A0: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_cont && rx0_sel == 2'h0 |-> host_int_line_a == events.pattern)
		else $error("rx continuous line a not pattern");
	AST_RX_CONT_A1: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_cont && rx0_sel == 2'h1
		|-> host_int_line_a == events.signal_strength_event)
		else $error("rx continuous line a not strength");
	AST_RX_CONT_A2: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_cont && rx0_sel[1] |-> host_int_line_a == events.start_detect)
		else $error("rx continuous line a not start");
	AST_RX_BUF_A0: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_buf && rx0_sel == 2'h0 |-> !host_int_line_a)
		else $error("rx buffered line a not low");
	AST_RX_BUF_A1: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_buf && rx0_sel == 2'h1 |-> host_int_line_a == events.byte_written)
		else $error("rx buffered line a not byte");
	AST_RX_BUF_A2: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_buf && rx0_sel == 2'h2 |-> host_int_line_a == (fill_count != 0))
		else $error("rx buffered line a not not-empty");
	AST_RX_BUF_A3: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_buf && rx0_sel == 2'h3 |-> host_int_line_a == events.start_detect)
		else $error("rx buffered line a not start");
	AST_RX_PKT_A0: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx0_sel == 2'h0 |-> host_int_line_a == events.data_ready)
		else $error("rx packet line a not ready");
	AST_RX_PKT_A1: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx0_sel == 2'h1 |-> host_int_line_a == events.byte_written)
		else $error("rx packet line a not byte");
	AST_RX_PKT_A2: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx0_sel == 2'h2 |-> host_int_line_a == (fill_count != 0))
		else $error("rx packet line a not not-empty");
	AST_RX_PKT_A3: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx0_sel == 2'h3 && address_compare_enable
		|-> host_int_line_a == events.addr_match)
		else $error("rx packet line a not address match");
	AST_RX_PKT_A3S: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx0_sel == 2'h3 && !address_compare_enable
		|-> host_int_line_a == events.start_detect)
		else $error("rx packet line a not start");
	AST_RX_BUF_B0: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_buf && rx1_sel == 2'h0 |-> !host_int_line_b)
		else $error("rx buffered line b not low");
	AST_RX_BUF_B1: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_buf && rx1_sel == 2'h1 && fill_count >= buffer_size
		|-> host_int_line_b)
		else $error("rx buffered line b not full");
	AST_RX_BUF_B2: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_buf && rx1_sel == 2'h2
		|-> host_int_line_b == events.signal_strength_event)
		else $error("rx buffered line b not strength");
	AST_RX_BUF_B3: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_buf && rx1_sel == 2'h3 && fill_count == thresh_bytes
		|-> host_int_line_b)
		else $error("rx buffered line b not threshold");
	AST_RX_PKT_B0: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx1_sel == 2'h0 |-> host_int_line_b == events.crc_good)
		else $error("rx packet line b not crc");
	AST_RX_PKT_B1: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx1_sel == 2'h1 && fill_count >= buffer_size
		|-> host_int_line_b)
		else $error("rx packet line b not full");
	AST_RX_PKT_B2: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx1_sel == 2'h2
		|-> host_int_line_b == events.signal_strength_event)
		else $error("rx packet line b not strength");
	AST_RX_PKT_B3: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		rx_pkt && rx1_sel == 2'h3 && fill_count < thresh_bytes
		|-> !host_int_line_b)
		else $error("rx packet line b early threshold");
	AST_TX_A_NE: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		tx_fb && tx0_sel |-> host_int_line_a == (fill_count != 0))
		else $error("tx line a not not-empty");
	AST_TX_A_THR: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		tx_fb && !tx0_sel && fill_count == thresh_bytes |-> host_int_line_a)
		else $error("tx line a not threshold");
	AST_TX_CONT_B: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		chip_mode == irr_pkg::CM_TX && data_mode == irr_pkg::DM_CONT
		|-> host_int_line_b == events.recovered_bit_clock)
		else $error("tx continuous line b not clock");
	AST_TX_B_FULL: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		tx_fb && !tx1_sel |-> host_int_line_b == (fill_count >= buffer_size))
		else $error("tx line b not full");
	AST_FULL_FLAG: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		fill_count == buffer_size |-> buffer_full)
		else $error("full flag missing at size");
	AST_EMPTY_FLAG: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		fill_count == 7'h00 |-> !buffer_not_empty)
		else $error("not-empty flag on empty buffer");
	AST_FREQ_SEL1: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		!frequency_select |-> synth_div.s == regs_r[2])
		else $error("first divider set not selected");
	AST_STBY_CONT: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		chip_mode == irr_pkg::CM_STANDBY && data_mode == irr_pkg::DM_CONT
		|-> !host_int_line_a && !host_int_line_b)
		else $error("lines active in standby continuous");
	AST_F1_RESET: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		$rose(rst_n_r) |-> regs_r[0] == irr_pkg::RST_F1_R)
		else $error("first divider reset value wrong");
	AST_F2_RESET: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		$rose(rst_n_r) |-> regs_r[3] == irr_pkg::RST_F2_R)
		else $error("second divider reset value wrong");
	AST_SIZE0: assert property (
		@(posedge sys_clk) disable iff (!rst_n_r)
		size_code == 2'h0 |-> buffer_size == 7'd16)
		else $error("smallest buffer size wrong");
endmodule : irr_router

`default_nettype wire

// ### logic/irr_pkg.sv
// package: register map, reset values and mode codes for the interrupt router
//
// What this block does
// - size field 00..11 gives 16..64 bytes
// - threshold bytes equal six-bit field plus one
// - threshold events fire when count reaches threshold
// - rx continuous line a: pattern, strength, start
// - rx buffered line a: low, byte, not-empty, start
// - rx packet line a: ready, byte, not-empty
// - rx packet code 11: address match or start
// - rx continuous line b: recovered bit clock always
// - rx buffered line b: low, full, strength, threshold
// - rx packet line b: crc, full, strength, threshold
// - tx continuous line a held low
// - tx buffered/packet line a: threshold or not-empty
// - tx continuous line b: data clock always
// - tx buffered/packet line b: full or tx-stop
// - read-only buffer full status at bit 1
// - read-only buffer not empty status at bit 0
// - frequency one dividers reset 6b, 2a, 1e
// - frequency two dividers reset 77, 2f, 19
// - frequency select picks divider set
`default_nettype none

package irr_pkg;
	localparam logic [7:0] OFS_F1_R     = 8'h06;
	localparam logic [7:0] OFS_F1_P     = 8'h07;
	localparam logic [7:0] OFS_F1_S     = 8'h08;
	localparam logic [7:0] OFS_F2_R     = 8'h09;
	localparam logic [7:0] OFS_F2_P     = 8'h0a;
	localparam logic [7:0] OFS_F2_S     = 8'h0b;
	localparam logic [7:0] OFS_BUF_CFG  = 8'h0c;
	localparam logic [7:0] OFS_IRQ_ROUT = 8'h0d;

	localparam logic [7:0] RST_F1_R     = 8'h6b;
	localparam logic [7:0] RST_F1_P     = 8'h2a;
	localparam logic [7:0] RST_F1_S     = 8'h1e;
	localparam logic [7:0] RST_F2_R     = 8'h77;
	localparam logic [7:0] RST_F2_P     = 8'h2f;
	localparam logic [7:0] RST_F2_S     = 8'h19;
	localparam logic [7:0] RST_BUF_CFG  = 8'h0f;
	localparam logic [7:0] RST_IRQ_ROUT = 8'h00;

	// field positions
	localparam int SIZE_LSB    = 6;
	localparam int RX0_LSB     = 6;
	localparam int RX1_LSB     = 4;
	localparam int TX0_BIT     = 3;
	localparam int TX1_BIT     = 2;
	localparam int FULL_BIT    = 1;
	localparam int NEMPTY_BIT  = 0;
	localparam logic [6:0] SIZE_UNIT = 7'h10;

	// chip mode codes
	localparam logic [2:0] CM_STANDBY = 3'h1;
	localparam logic [2:0] CM_RX      = 3'h3;
	localparam logic [2:0] CM_TX      = 3'h4;
	// data mode codes
	localparam logic [1:0] DM_CONT    = 2'h0;
	localparam logic [1:0] DM_BUF     = 2'h1;

	typedef struct packed {
		logic pattern;
		logic start_detect;
		logic signal_strength_event;
		logic byte_written;
		logic data_ready;
		logic addr_match;
		logic crc_good;
		logic recovered_bit_clock;
		logic tx_stop;
	} irr_events_t;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] p;
		logic [7:0] s;
	} irr_synth_t;
endpackage : irr_pkg

`default_nettype wire

// ### test/irr_host.sv
// host model: register bus master facing the router
`default_nettype none

module irr_host (
	input  wire logic       clk,   // system clock
	output logic      [7:0] addr,  // register address
	output logic      [7:0] wdata, // write data
	output logic            wr,    // write strobe
	output logic            rd     // read strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// ==========================================
	// bus cycles
	// released lines show the inverse, so stale values never match
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		addr  <= ~a;
		wdata <= ~d;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		addr <= ~a;
	endtask : rd_reg
endmodule : irr_host

`default_nettype wire

// ### test/irr_router_tb.sv
// self-checking bench for the interrupt router
`default_nettype none

module irr_router_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 clk = 1'b0;
	logic                 arst_n = 1'b0;
	logic [7:0]           addr, wdata, rdata, a;
	logic                 wr, rd, rd_q = 1'b0;
	logic [2:0]           cm = 3'h0;
	logic [1:0]           dm = 2'h0;
	logic                 fsel = 1'b0, ace = 1'b0;
	logic [6:0]           fc = 7'h00, bsz, thb;
	irr_pkg::irr_events_t ev = '0;
	irr_pkg::irr_synth_t  sd;
	logic                 full, ne, la, lb;
	logic [7:0]           rf [6:13] = '{8'h6b, 8'h2a, 8'h1e, 8'h77,
		8'h2f, 8'h19, 8'h0f, 8'h00};
	logic [7:0]           exp_q [$];
	integer               seed = 32'h7e47;
	int                   err_total = 0, checks_done = 0;

	always #10 clk = ~clk;

	irr_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd));
	irr_router u_dut (.sys_clk(clk), .arst_n(arst_n), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
		.chip_mode(cm), .data_mode(dm), .frequency_select(fsel),
		.address_compare_enable(ace), .fill_count(fc), .events(ev),
		.synth_div(sd), .buffer_size(bsz), .thresh_bytes(thb),
		.buffer_full(full), .buffer_not_empty(ne),
		.host_int_line_a(la), .host_int_line_b(lb));

	// ==========================================
	// helpers
	task automatic chk(input logic [23:0] e, input logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk

	task automatic conclude();
		if (err_total == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	function automatic logic [6:0] size_ref();
		return {rf[12][7:6], 4'h0} + 7'h10;
	endfunction : size_ref

	function automatic logic [6:0] thr_ref();
		return 7'(rf[12][5:0]) + 7'h01;
	endfunction : thr_ref

	function automatic logic [1:0] route_ref();
		logic [7:0] r;
		logic [3:0] va;
		logic [3:0] vb;
		logic       th;
		logic       fl;
		logic       nz;
		r  = rf[13];
		nz = fc != 7'h00;
		fl = fc >= size_ref();
		th = fc >= thr_ref();
		va = (dm == 2'h0) ? {ev.start_detect, ev.start_detect,
			ev.signal_strength_event, ev.pattern} : (dm == 2'h1) ?
			{ev.start_detect, nz, ev.byte_written, 1'b0} :
			{ace ? ev.addr_match : ev.start_detect, nz, ev.byte_written,
			ev.data_ready};
		vb = (dm == 2'h0) ? {4{ev.recovered_bit_clock}} :
			{th, ev.signal_strength_event, fl,
			(dm == 2'h1) ? 1'b0 : ev.crc_good};
		case (cm)
			3'h3: return {va[r[7:6]], vb[r[5:4]]};
			3'h4: return (dm == 2'h0) ? {1'b0, ev.recovered_bit_clock} :
				{r[3] ? nz : th, r[2] ? ev.tx_stop : fl};
			3'h1: return {dm != 2'h0 && r[7:6] == 2'h2 && nz,
				dm != 2'h0 && r[5:4] == 2'h3 && th ||
				dm[1] && r[5:4] == 2'h1 && fl};
			default: return 2'h0;
		endcase
	endfunction : route_ref

	// unmapped places read as zero, status bits follow the fill count
	task automatic rd_exp(input logic [7:0] ra);
		exp_q.push_back((ra inside {[8'h06:8'h0c]}) ? rf[ra] :
			(ra == 8'h0d) ? {rf[13][7:2], fc >= size_ref(), fc != 7'h00} :
			8'h00);
		u_host.rd_reg(ra);
	endtask : rd_exp

	// ==========================================
	// watcher: read data stands only in the cycle after the strobe
	always @(posedge clk) rd_q <= rd;
	always @(negedge clk) begin
		if (rd_q) begin
			if (exp_q.size() == 0) begin
				chk(24'h0000ee, 24'(rdata));
			end else begin
				chk(24'(exp_q.pop_front()), 24'(rdata));
			end
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		conclude();
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(24'(thb), 24'h000010);
		for (int i = 5; i < 15; i++) rd_exp(8'(i));
		u_host.wr_reg(8'h0e, 8'h5a);
		rd_exp(8'h0e);
		for (int i = 0; i < 400; i++) begin
			a = 8'h06 + 8'($random(seed) & 7);
			rf[a] = 8'($random(seed));
			u_host.wr_reg(a, rf[a]);
			rf[13] = 8'($random(seed));
			u_host.wr_reg(8'h0d, rf[13]);
			rd_exp(a);
			@(posedge clk);
			cm   <= 3'($random(seed));
			dm   <= 2'($random(seed));
			fsel <= 1'($random(seed));
			ace  <= 1'($random(seed));
			ev   <= 9'($random(seed));
			fc   <= 7'($unsigned($random(seed)) % 65);
			@(negedge clk);
			chk(24'(route_ref()), 24'({la, lb}));
			chk(24'({size_ref(), thr_ref()}), 24'({bsz, thb}));
			chk(24'({fc >= size_ref(), fc != 7'h00}), 24'({full, ne}));
			chk(fsel ? {rf[9], rf[10], rf[11]} : {rf[6], rf[7], rf[8]},
				sd);
		end
		repeat (2) @(posedge clk);
		conclude();
	end
endmodule : irr_router_tb

`default_nettype wire
